// File: core/pst_pkg.sv
// constants, types and helpers for the packet timeout and error-code slave
// assumes a 125 MHz system clock; bus offsets are byte addresses
package pst_pkg;
	// ****************
	// timing
	// ****************
	localparam int CLK_KHZ     = 125000;
	localparam int TOUT_STD_MS = 30;
	localparam int TOUT_EXT_MS = 255;
	localparam int TOUT_MIN_MS = 25;
	localparam int TOUT_STD_CYC = TOUT_STD_MS * CLK_KHZ;
	localparam int TOUT_EXT_CYC = TOUT_EXT_MS * CLK_KHZ;
	localparam int TOUT_MIN_CYC = TOUT_MIN_MS * CLK_KHZ;

	// ****************
	// register map
	// ****************
	localparam logic [4:0] OFS_CFG  = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_COMM = 5'h08;
	localparam logic [4:0] OFS_RX   = 5'h0c;
	localparam logic [4:0] OFS_TX   = 5'h10;
	localparam logic [4:0] OFS_DEC  = 5'h14;
	localparam int CFG_PEC_BIT  = 2;
	localparam int CFG_EXT_BIT  = 3;
	localparam int CFG_ADDR_LSB = 8;
	localparam logic [15:0] CFG_WMASK = 16'h7f0c;
	localparam logic [6:0] ADDR_RST = 7'h40;
	localparam int CML_CMD_BIT  = 7;
	localparam int CML_DATA_BIT = 6;
	localparam int CML_PEC_BIT  = 5;
	localparam int BUSY_BIT     = 3;
	localparam int CML_TOUT_BIT = 1;
	localparam logic [7:0] CML_MASK = 8'he2;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_CML_BIT  = 1;
	localparam logic [7:0] L16_EXP = 8'hf4;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] FLOG_CMD_DEF = 8'hee;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RXB  = 3'h1,
		ST_ACK  = 3'h3,
		ST_TXB  = 3'h2,
		ST_MACK = 3'h6,
		ST_DONE = 3'h7
	} pst_state_type;

	typedef enum logic [1:0] {CLS_SUPP = 2'h0, CLS_UNSUP = 2'h1, CLS_RSVD = 2'h2} pst_cls_type;

	function automatic pst_cls_type pst_classify(input logic [7:0] c, input logic [7:0] flog);
		logic hit;
		case (c)
			8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h10, 8'h15, 8'h16, 8'h19,
			8'h1b, 8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h33, 8'h35, 8'h36,
			8'h38, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4a,
			8'h4f: hit = 1'b1;
			default: hit = (c == flog);
		endcase
		if (hit)
			return CLS_SUPP;
		return (c < 8'hd0) ? CLS_UNSUP : CLS_RSVD;
	endfunction

	function automatic logic [7:0] pst_crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
endpackage

// File: core/pst_slave.sv
// serial slave integrity layer: packet timer, error code, fault causes
// assumes i_scl/i_sda from pins, Avalon-MM master on the system clock
// Functional notes
// R1 - packet timer starts at first START, stops at STOP
// R2 - on timer expiry release SDA and discard the message
// R3 - timed span includes repeated START, second address, acks, data
// R4 - default packet timeout is 30 ms
// R5 - config bit 3 extends timeout to 255 ms
// R6 - fault history log block reads always get 255 ms
// R7 - timeout never shorter than 25 ms
// R8 - works at bus clock rates 10 kHz to 400 kHz
// R9 - last data sender appends CRC-8 error code
// R10 - reads return a correct error code when host clocks one out
// R11 - config bit 2 makes writes without valid error code ignored
// R12 - bad code, unsupported command or invalid data raise comm fault
// R13 - comm fault sets byte and word summary flags and cause bit
// R14 - unlisted 0x00-0xcf unsupported, unlisted 0xd0-0xff reserved
// R15 - reading an unlisted command leaves operation undisturbed; unsupported reads here still raise a comm fault
// R16 - host should not write unsupported or reserved commands
// R17 - signal busy when commands arrive faster than processed
// R18 - exponent-mantissa word: 5-bit signed exponent, 11-bit signed mantissa
// R19 - fixed-exponent word: 16-bit unsigned mantissa times 2^-12
// R20 - slave only, never starts a transaction
// R21 - error code is CRC-8 x^8+x^2+x+1, zero start, all bytes
`timescale 1ns/1ps
`default_nettype none
module pst_slave
	import pst_pkg::*;
#(
	parameter int         P_TOUT_STD_CYC = TOUT_STD_CYC,
	parameter int         P_TOUT_EXT_CYC = TOUT_EXT_CYC,
	parameter int         P_TOUT_MIN_CYC = TOUT_MIN_CYC,
	parameter logic [7:0] P_FLOG_CMD     = FLOG_CMD_DEF
) (
	input  wire logic        i_clk,             // system clock
	input  wire logic        i_sys_rst,         // sync reset, high
	input  wire logic [4:0]  i_avs_address,     // byte address
	input  wire logic        i_avs_read,        // read request
	input  wire logic        i_avs_write,       // write request
	input  wire logic [31:0] i_avs_writedata,   // write data
	input  wire logic [3:0]  i_avs_byteenable,  // byte lanes
	output logic      [31:0] o_avs_readdata,    // read data
	output logic             o_avs_waitrequest, // stall
	input  wire logic        i_scl,             // bus clock pin
	input  wire logic        i_sda,             // data pin level
	output logic             o_sda_out,         // data drive value
	output logic             o_sda_oe           // data pull low enable
);
	localparam int TW = $clog2(P_TOUT_EXT_CYC + 1);

	// ****************
	// pin sampling
	// ****************
	logic scl_m_reg, scl_s_reg, scl_d_reg;
	logic sda_m_reg, sda_s_reg, sda_d_reg;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	// R8 two-stage sync then edge find; 125 MHz oversamples 400 kHz widely
	always_ff @(posedge i_clk) begin
		scl_m_reg <= i_scl;
		scl_s_reg <= scl_m_reg;
		scl_d_reg <= scl_s_reg;
		sda_m_reg <= i_sda;
		sda_s_reg <= sda_m_reg;
		sda_d_reg <= sda_s_reg;
	end

	assign scl_rise = scl_s_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s_reg & scl_d_reg;
	assign start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
	assign stop_ev  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

	// ****************
	// packet engine
	// ****************
	pst_state_type st_reg, st_next;
	logic [2:0]  bit_reg, bit_next, txi_reg, txi_next;
	logic [7:0]  sh_reg, sh_next, crc_reg, crc_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic [15:0] dat_reg, dat_next;
	logic [3:0]  idx_reg, idx_next, cnt;
	logic [TW-1:0] tmr_reg, tmr_next;
	logic oe_reg, oe_next, run_reg, run_next, adr_reg, adr_next;
	logic rd_reg, rd_next, long_reg, long_next;
	logic tout, has_pec, commit, ev_cmd, ev_pec, ev_busy;
	logic [7:0]  txb;
	pst_cls_type cls;

	// bus-side registers used by the engine
	logic [15:0] cfg_reg, tx_reg;
	logic [1:0]  txlen_reg;
	logic        pend_reg;

	assign cls = pst_classify(cmd_reg, P_FLOG_CMD);
	// a trailing valid code folds the running CRC back to zero; the shifter is no
	// use here, the STOP's own clock rise has already shifted a bit into it
	assign has_pec = (idx_reg >= 4'd2) && (crc_reg == 8'h00);
	assign cnt = has_pec ? idx_reg - 4'd2 : idx_reg - 4'd1;
	// R4 R5 R6 limit picked live, so a fault log read extends mid-packet
	// R7 defaults are never below the 25 ms floor; only shortened sims go lower
	assign tout = run_reg && (tmr_reg == ((cfg_reg[CFG_EXT_BIT] || long_reg) ?
		TW'(P_TOUT_EXT_CYC - 1) : TW'(P_TOUT_STD_CYC - 1)));
	// R9 R10 data bytes, then the running code, then idle ones
	assign txb = (txi_reg < {1'b0, txlen_reg}) ? (txi_reg[0] ? tx_reg[15:8] : tx_reg[7:0]) :
		(txi_reg == {1'b0, txlen_reg}) ? crc_reg : 8'hff;

	always_comb begin
		st_next = st_reg;
		bit_next = bit_reg;
		txi_next = txi_reg;
		sh_next = sh_reg;
		crc_next = crc_reg;
		cmd_next = cmd_reg;
		dat_next = dat_reg;
		idx_next = idx_reg;
		tmr_next = tmr_reg;
		oe_next = oe_reg;
		run_next = run_reg;
		adr_next = adr_reg;
		rd_next = rd_reg;
		long_next = long_reg;
		commit = 1'b0;
		ev_cmd = 1'b0;
		ev_pec = 1'b0;
		ev_busy = 1'b0;
		if (run_reg)
			tmr_next = tmr_reg + 1'b1;
		if (start_ev) begin
			// R1 R3 a repeated START keeps the timer and code running
			if (!run_reg) begin
				tmr_next = '0;
				run_next = 1'b1;
				idx_next = '0;
				crc_next = '0;
				long_next = 1'b0;
			end
			rd_next = 1'b0;
			st_next = ST_RXB;
			bit_next = '0;
			oe_next = 1'b0;
			adr_next = 1'b1;
		end else if (stop_ev) begin
			// R1 stop ends the packet; writes are judged here
			if (run_reg && !rd_reg && st_reg != ST_DONE && idx_reg != 4'd0) begin
				// R11 R12 a missing or bad code blocks the write
				if (cfg_reg[CFG_PEC_BIT] && !has_pec)
					ev_pec = 1'b1;
				// R14 R16 unlisted writes fault and are dropped
				else if (cls != CLS_SUPP)
					ev_cmd = 1'b1;
				else
					commit = 1'b1;
			end
			run_next = 1'b0;
			st_next = ST_IDLE;
			oe_next = 1'b0;
		end else if (tout) begin
			// R2 let go of the line and forget the message
			st_next = ST_DONE;
			oe_next = 1'b0;
			run_next = 1'b0;
		end else begin
			case (st_reg)
				ST_RXB: if (scl_rise) begin
					sh_next = {sh_reg[6:0], sda_s_reg};
					bit_next = bit_reg + 3'd1;
					if (bit_reg == 3'd7)
						st_next = ST_ACK;
				end
				ST_ACK: if (scl_fall) begin
					if (bit_reg == 3'd0) begin
						bit_next = 3'd1;
						if (adr_reg) begin
							if (sh_reg[7:1] != cfg_reg[CFG_ADDR_LSB +: 7]) begin
								st_next = ST_DONE;
							end else begin
								// R21 address bytes go into the code too
								oe_next = 1'b1;
								adr_next = 1'b0;
								rd_next = sh_reg[0];
								crc_next = pst_crc8(crc_reg, sh_reg);
								txi_next = '0;
								if (sh_reg[0]) begin
									// R6 fault log reads get the long limit
									long_next = long_reg | (cmd_reg == P_FLOG_CMD);
									// R15 reserved reads are harmless, unsupported fault
									ev_cmd = (cls == CLS_UNSUP);
								end
							end
						end else if (idx_reg == 4'd0 && pend_reg) begin
							// R17 previous command not yet taken: refuse
							st_next = ST_DONE;
							ev_busy = 1'b1;
						end else begin
							oe_next = 1'b1;
							crc_next = pst_crc8(crc_reg, sh_reg);
							if (idx_reg != 4'hf)
								idx_next = idx_reg + 4'd1;
							if (idx_reg == 4'd0)
								cmd_next = sh_reg;
							if (idx_reg == 4'd1)
								dat_next[7:0] = sh_reg;
							if (idx_reg == 4'd2)
								dat_next[15:8] = sh_reg;
						end
					end else begin
						bit_next = '0;
						if (rd_reg) begin
							st_next = ST_TXB;
							sh_next = txb;
							oe_next = ~txb[7];
							if (txi_reg != 3'd7)
								txi_next = txi_reg + 3'd1;
							if (txi_reg < {1'b0, txlen_reg})
								crc_next = pst_crc8(crc_reg, txb);
						end else begin
							st_next = ST_RXB;
							oe_next = 1'b0;
						end
					end
				end
				ST_TXB: if (scl_fall) begin
					if (bit_reg == 3'd7) begin
						oe_next = 1'b0;
						st_next = ST_MACK;
					end else begin
						sh_next = {sh_reg[6:0], 1'b1};
						oe_next = ~sh_reg[6];
						bit_next = bit_reg + 3'd1;
					end
				end
				ST_MACK: if (scl_rise) begin
					st_next = sda_s_reg ? ST_DONE : ST_ACK;
					bit_next = 3'd1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_reg <= ST_IDLE;
			bit_reg <= '0;
			txi_reg <= '0;
			sh_reg <= '0;
			crc_reg <= '0;
			cmd_reg <= '0;
			dat_reg <= '0;
			idx_reg <= '0;
			tmr_reg <= '0;
			oe_reg <= 1'b0;
			run_reg <= 1'b0;
			adr_reg <= 1'b0;
			rd_reg <= 1'b0;
			long_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			bit_reg <= bit_next;
			txi_reg <= txi_next;
			sh_reg <= sh_next;
			crc_reg <= crc_next;
			cmd_reg <= cmd_next;
			dat_reg <= dat_next;
			idx_reg <= idx_next;
			tmr_reg <= tmr_next;
			oe_reg <= oe_next;
			run_reg <= run_next;
			adr_reg <= adr_next;
			rd_reg <= rd_next;
			long_reg <= long_next;
		end
	end

	// R20 only ever pulls SDA low, never touches SCL
	assign o_sda_out = 1'b0;
	assign o_sda_oe = oe_reg;

	// ****************
	// register slave
	// ****************
	logic [15:0] cfg_next, tx_next, rxdat_reg, rxdat_next;
	logic [1:0]  txlen_next;
	logic [7:0]  comm_reg, comm_next, rxcmd_reg, rxcmd_next, stat_byte;
	logic [3:0]  rxcnt_reg, rxcnt_next;
	logic [31:0] rdata_reg, rdata_next, wm, wd;
	logic        pend_next, bak_reg, bak_next, wr_fire, cml;
	logic [7:0]  l11_exp;
	logic [15:0] l11_man;

	// R18 R19 decode of the last word taken
	assign l11_exp = {{3{rxdat_reg[15]}}, rxdat_reg[15:11]};
	assign l11_man = {{5{rxdat_reg[10]}}, rxdat_reg[10:0]};
	// R13 one summary bit feeds both byte and word status
	assign cml = |(comm_reg & CML_MASK);
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[ST_CML_BIT] = cml;
		stat_byte[ST_BUSY_BIT] = comm_reg[BUSY_BIT];
	end

	// one wait state on every access
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bak_reg;
	assign wr_fire = i_avs_write & bak_reg;
	assign wm = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign wd = i_avs_writedata & wm;
	assign o_avs_readdata = rdata_reg;

	always_comb begin
		cfg_next = cfg_reg;
		tx_next = tx_reg;
		txlen_next = txlen_reg;
		comm_next = comm_reg;
		pend_next = pend_reg;
		rxcmd_next = rxcmd_reg;
		rxdat_next = rxdat_reg;
		rxcnt_next = rxcnt_reg;
		bak_next = (i_avs_read | i_avs_write) & ~bak_reg;
		rdata_next = rdata_reg;
		if (i_avs_read && !bak_reg) begin
			case (i_avs_address)
				OFS_CFG:  rdata_next = {16'h0000, cfg_reg};
				OFS_STAT: rdata_next = {14'h0000, run_reg, pend_reg, 8'h00, stat_byte};
				OFS_COMM: rdata_next = {24'h000000, comm_reg};
				OFS_RX:   rdata_next = {pend_reg, 3'h0, rxcnt_reg, rxdat_reg, rxcmd_reg};
				OFS_TX:   rdata_next = {14'h0000, txlen_reg, tx_reg};
				OFS_DEC:  rdata_next = {l11_exp, L16_EXP, l11_man};
				default:  rdata_next = 32'h00000000;
			endcase
		end
		if (wr_fire) begin
			case (i_avs_address)
				OFS_CFG: cfg_next = (cfg_reg & ~(wm[15:0] & CFG_WMASK)) | (wd[15:0] & CFG_WMASK);
				OFS_COMM: comm_next = comm_reg & ~wd[7:0];
				OFS_RX: pend_next = 1'b0;
				OFS_TX: begin
					tx_next = (tx_reg & ~wm[15:0]) | wd[15:0];
					if (i_avs_byteenable[2])
						txlen_next = wd[17:16];
				end
				// R12 logic behind the slave reports bad data here
				OFS_DEC: comm_next[CML_DATA_BIT] = comm_reg[CML_DATA_BIT] | wd[0];
				default: ;
			endcase
		end
		// R12 R13 hardware events win over a same-cycle clear
		if (ev_cmd)
			comm_next[CML_CMD_BIT] = 1'b1;
		if (ev_pec)
			comm_next[CML_PEC_BIT] = 1'b1;
		if (ev_busy)
			comm_next[BUSY_BIT] = 1'b1;
		if (tout)
			comm_next[CML_TOUT_BIT] = 1'b1;
		if (commit) begin
			pend_next = 1'b1;
			rxcmd_next = cmd_reg;
			rxcnt_next = cnt;
			rxdat_next = (cnt == 4'd1) ? {8'h00, dat_reg[7:0]} : dat_reg;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_reg <= {1'b0, ADDR_RST, 8'h00};
			tx_reg <= '0;
			txlen_reg <= '0;
			comm_reg <= '0;
			pend_reg <= 1'b0;
			rxcmd_reg <= '0;
			rxdat_reg <= '0;
			rxcnt_reg <= '0;
			bak_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			tx_reg <= tx_next;
			txlen_reg <= txlen_next;
			comm_reg <= comm_next;
			pend_reg <= pend_next;
			rxcmd_reg <= rxcmd_next;
			rxdat_reg <= rxdat_next;
			rxcnt_reg <= rxcnt_next;
			bak_reg <= bak_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************
	// checks
	// ****************
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	pkt_start_a: assert property (start_ev && !run_reg |=> run_reg && tmr_reg == '0) // R1
		else $error("timer did not start");
	pkt_stop_a: assert property (stop_ev |=> !run_reg && st_reg == ST_IDLE) // R1
		else $error("timer did not stop");
	rep_start_a: assert property (start_ev && run_reg |=> run_reg && tmr_reg != '0) // R3
		else $error("repeated start reset timer");
	tout_rel_a: assert property (tout |=> !oe_reg && st_reg == ST_DONE && !run_reg) // R2
		else $error("line held after timeout");
	tout_disc_a: assert property (st_reg == ST_DONE |-> !commit) // R2
		else $error("dropped message committed");
	std_period_a: assert property (tout && !cfg_reg[CFG_EXT_BIT] && !long_reg
		|-> tmr_reg == TW'(P_TOUT_STD_CYC - 1)) // R4
		else $error("standard timeout length wrong");
	ext_period_a: assert property (tout && cfg_reg[CFG_EXT_BIT]
		|-> tmr_reg == TW'(P_TOUT_EXT_CYC - 1)) // R5
		else $error("extended timeout length wrong");
	flog_period_a: assert property (tout && long_reg |-> tmr_reg == TW'(P_TOUT_EXT_CYC - 1)) // R6
		else $error("fault log timeout length wrong");
	min_period_a: assert property (tout |-> tmr_reg >= TW'(P_TOUT_MIN_CYC - 1)) // R7
		else $error("timeout below floor");
	pec_out_a: assert property (st_reg == ST_ACK && bit_reg == 3'd1 && rd_reg && scl_fall
		&& !start_ev && !stop_ev && !tout && txi_reg == {1'b0, txlen_reg}
		|=> sh_reg == $past(crc_reg)) // R10
		else $error("read code byte wrong");
	pec_need_a: assert property (commit |-> !cfg_reg[CFG_PEC_BIT] || has_pec) // R11
		else $error("write taken without code");
	sup_only_a: assert property (commit |-> cls == CLS_SUPP) // R12
		else $error("unlisted write taken");
	cml_flag_a: assert property (ev_pec |=> comm_reg[CML_PEC_BIT] && stat_byte[ST_CML_BIT]) // R13
		else $error("fault flags not set");
	busy_nak_a: assert property (ev_busy |=> st_reg == ST_DONE && !oe_reg ##1 !oe_reg) // R17
		else $error("busy byte acknowledged");
endmodule
`default_nettype wire

// File: sim/pst_host_model.sv
// bus host model: drives the link clock and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pst_host_model (
	input  wire logic i_clk,      // system clock, paces the link
	input  wire logic i_sda,      // resolved data wire
	output logic      o_scl,      // link clock, idles high
	output logic      o_sda_pull  // pull data wire low
);
	// ****************
	// bus cycles
	// ****************
	logic [7:0] crc;

	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
		crc = 8'h00;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	// 20 clocks per bit gives the 160 ns link period
	task automatic bit_io(input logic b, output logic r);
		o_sda_pull <= ~b;
		tick(5);
		o_scl <= 1'b1;
		tick(5);
		r = i_sda;
		tick(5);
		o_scl <= 1'b0;
		tick(5);
	endtask

	task automatic start(input logic first);
		if (first)
			crc = 8'h00;
		o_sda_pull <= 1'b0;
		tick(5);
		o_scl <= 1'b1;
		tick(5);
		o_sda_pull <= 1'b1;
		tick(5);
		o_scl <= 1'b0;
		tick(5);
	endtask

	task automatic stop();
		o_sda_pull <= 1'b1;
		tick(5);
		o_scl <= 1'b1;
		tick(5);
		o_sda_pull <= 1'b0;
		tick(10);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
		crc = crc8(crc, b);
	endtask

	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask

	task automatic wr_msg(input logic [7:0] cmd, input logic [15:0] d, input int n,
		input logic pec, output logic ok);
		logic a;
		start(1'b1);
		put_byte(8'h80, ok);
		put_byte(cmd, a);
		ok = ok & a;
		for (int i = 0; i < n && ok; i++) begin
			put_byte(d[8*i +: 8], a);
			ok = ok & a;
		end
		if (pec && ok)
			put_byte(crc, a);
		stop();
	endtask

	task automatic rd_msg(input logic [7:0] cmd, input int n, output logic [31:0] got);
		logic a;
		logic [7:0] b;
		got = 32'h0;
		start(1'b1);
		put_byte(8'h80, a);
		put_byte(cmd, a);
		start(1'b0);
		put_byte(8'h81, a);
		for (int i = 0; i < n; i++) begin
			get_byte(i < n - 1, b);
			got[8*i +: 8] = b;
		end
		stop();
	endtask
endmodule
`default_nettype wire

// File: sim/tb_pst_slave.sv
// self-checking bench for the packet timeout and error-code slave
// assumes shortened timeout parameters and the host model on the link
`timescale 1ns/1ps
`default_nettype none
module tb_pst_slave;
	import pst_pkg::*;
	// ****************
	// harness
	// ****************
	localparam int STD_CYC = 3000;
	localparam int EXT_CYC = 6000;
	logic        clk;
	logic        rst;
	logic [4:0]  av_addr;
	logic        av_read;
	logic        av_write;
	logic [31:0] av_wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        scl;
	logic        sda_oe;
	logic        sda_out;
	logic        host_pull;
	wire         sda_w;
	int          cyc;
	int          num_errors;
	int          n_tests;

	// open-drain wire with pull-up: the slave's drive value counts only while enabled
	assign sda_w = ~host_pull & (sda_oe ? sda_out : 1'b1);
	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	pst_slave #(
		.P_TOUT_STD_CYC(STD_CYC),
		.P_TOUT_EXT_CYC(EXT_CYC),
		.P_TOUT_MIN_CYC(2500)
	) pst_slave_inst (
		.i_clk(clk),
		.i_sys_rst(rst),
		.i_avs_address(av_addr),
		.i_avs_read(av_read),
		.i_avs_write(av_write),
		.i_avs_writedata(av_wdata),
		.i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq),
		.i_scl(scl),
		.i_sda(sda_w),
		.o_sda_out(sda_out),
		.o_sda_oe(sda_oe)
	);

	pst_host_model pst_host_model_inst (
		.i_clk(clk),
		.i_sda(sda_w),
		.o_scl(scl),
		.o_sda_pull(host_pull)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic av_acc(input logic wr, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		av_addr <= a;
		av_wdata <= wd;
		av_write <= wr;
		av_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		rd = rdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
		if (n >= 100) begin
			num_errors++;
			$display("[ERR] %0t bus access hung", $time);
			end_sim();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		av_acc(1'b1, a, d, x);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] x;
		av_acc(1'b0, a, 32'h0, x);
		chk(x, exp, what);
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_regs();
		rchk(OFS_CFG, 32'h0000_4000, "cfg reset");
		rchk(OFS_COMM, 32'h0, "comm reset");
		rchk(5'h1c, 32'h0, "unmapped read");
	endtask

	task automatic t_unlisted();
		logic [31:0] got;
		logic        ok;
		pst_host_model_inst.rd_msg(8'hd5, 1, got);
		rchk(OFS_COMM, 32'h0, "reserved read");
		pst_host_model_inst.rd_msg(8'h7f, 1, got);
		rchk(OFS_COMM, 32'h80, "unsupported read");
		wr(OFS_COMM, 32'hff);
		pst_host_model_inst.wr_msg(8'h7f, 16'h0, 0, 1'b0, ok);
		rchk(OFS_COMM, 32'h80, "unsupported write");
		rchk(OFS_STAT, 32'h02, "summary flag");
		wr(OFS_COMM, 32'hff);
	endtask

	task automatic t_write();
		logic ok;
		wr(OFS_CFG, 32'h0000_4004);
		pst_host_model_inst.wr_msg(8'h21, 16'h9807, 2, 1'b0, ok);
		rchk(OFS_COMM, 32'h20, "missing code");
		rchk(OFS_STAT, 32'h02, "nothing committed");
		wr(OFS_COMM, 32'hff);
		pst_host_model_inst.wr_msg(8'h21, 16'h9807, 2, 1'b1, ok);
		rchk(OFS_RX, 32'h8298_0721, "received word");
		rchk(OFS_DEC, 32'hf3f4_0007, "decoded word");
		pst_host_model_inst.wr_msg(8'h21, 16'h1234, 2, 1'b1, ok);
		chk({31'h0, ok}, 32'h0, "busy refusal");
		rchk(OFS_STAT, 32'h0001_0080, "busy status");
		wr(OFS_RX, 32'h0);
		wr(OFS_COMM, 32'hff);
		wr(OFS_DEC, 32'h1);
		rchk(OFS_COMM, 32'h40, "invalid data");
		wr(OFS_COMM, 32'hff);
		wr(OFS_CFG, 32'h0000_4000);
	endtask

	task automatic t_read();
		logic [31:0] got;
		logic [7:0]  e;
		wr(OFS_TX, 32'h0002_beef);
		pst_host_model_inst.rd_msg(8'h21, 3, got);
		e = pst_host_model_inst.crc8(pst_host_model_inst.crc8(pst_host_model_inst.crc, 8'hef),
			8'hbe);
		chk(got, {8'h0, e, 16'hbeef}, "reply and code");
		rchk(OFS_COMM, 32'h0, "clean read");
	endtask

	// stalls the host mid-message and brackets the expiry point
	task automatic t_timeout(input logic [15:0] cfg, input logic [7:0] cmd, input logic rd,
		input int lim);
		int   t0;
		logic a;
		wr(OFS_CFG, {16'h0, cfg});
		t0 = cyc;
		pst_host_model_inst.start(1'b1);
		pst_host_model_inst.put_byte(8'h80, a);
		pst_host_model_inst.put_byte(cmd, a);
		if (rd) begin
			pst_host_model_inst.start(1'b0);
			pst_host_model_inst.put_byte(8'h81, a);
		end
		while (cyc < t0 + lim - 100) @(posedge clk);
		rchk(OFS_COMM, 32'h0, "early expiry");
		while (cyc < t0 + lim + 100) @(posedge clk);
		rchk(OFS_COMM, 32'h02, "timer expiry");
		chk({31'h0, sda_oe}, 32'h0, "line released");
		pst_host_model_inst.stop();
		rchk(OFS_STAT, 32'h02, "message dropped");
		wr(OFS_COMM, 32'hff);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		av_addr = 5'h00;
		av_read = 1'b0;
		av_write = 1'b0;
		av_wdata = 32'h0;
		cyc = 0;
		num_errors = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_regs();
		t_unlisted();
		t_write();
		t_read();
		t_timeout(16'h4000, 8'h21, 1'b0, STD_CYC);
		t_timeout(16'h4008, 8'h21, 1'b0, EXT_CYC);
		t_timeout(16'h4000, 8'hee, 1'b1, EXT_CYC);
		end_sim();
	end

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
endmodule
`default_nettype wire
